// *** core/gp_ram.sv ***
// Purpose: general-purpose register storage with registered read
// Assumes: one read or write port, synchronous reset
// Notes:   read data appear one edge after the address
`timescale 1ns/1ps
`default_nettype none

module gp_ram #(
    parameter int DEPTH  = 224,
    parameter int WIDTH  = 8,
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk_i,  // core clock
    input  wire logic              reset_i,    // sync reset, high
    input  wire logic              we_i,       // write strobe
    input  wire logic [ADDR_W-1:0] addr_i,     // location
    input  wire logic [WIDTH-1:0]  wdata_i,    // write data
    output logic      [WIDTH-1:0]  rdata_o     // registered read data
);

    // refuse a depth the address cannot reach
    if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin : g_bad_depth
        $error("gp_ram depth out of range");
    end

    // state of the memory: contents and output register
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage cells
        logic [WIDTH-1:0]            rdata; // read register
    } ram_state_t;

    ram_state_t q;  // current state
    ram_state_t d;  // next state

    // write and read of the addressed cell
    always_comb begin
        d = q;
        if (32'(addr_i) < DEPTH) begin
            d.rdata = q.mem[addr_i];
            if (we_i) begin
                d.mem[addr_i] = wdata_i;
            end
        end else begin
            d.rdata = '0;
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;

endmodule : gp_ram

`default_nettype wire

// *** core/paged_register_file_decoder.sv ***
// Purpose: register file decode, system group and paged window
// Assumes: core issues one register access per cycle, peripherals
//          answer a page read in the cycle their strobe is high
// Notes:   every read answers exactly two edges after it is taken
//          and a page with no peripheral reads as all ones; both
//          pointers live in the system group
//
// Notes on behaviour
// - 240 directly addressed byte registers, 8-bit address
// - addresses 0..223 are general-purpose storage
// - addresses 224..239 are the system group
// - addresses 240..255 window the selected page
// - up to 64 pages of 16 peripheral registers
// - dedicated 8-bit register bus, apart from memory
// - program, data and register spaces are distinct
// - 6-bit interrupt/dma bus between core and peripherals
// - page pointer at 234 selects page, persists
// - working address: pointer high nibble, instruction low
// - pages exist only where a peripheral exists
`include "regfile_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module paged_register_file_decoder #(
    // pages whose peripheral is fitted, one bit per page
    parameter logic [`RF_PAGE_COUNT-1:0] PAGE_PRESENT =
        64'h0000_0000_0000_000f,
    parameter int                        GP_COUNT     = `RF_GP_COUNT
) (
    input  wire logic                      ref_clk_i,      // core clock
    input  wire logic                      reset_i,        // sync reset
    // register addressing bus from the core
    input  wire logic [`RF_ADDR_W-1:0]     reg_addr_i,     // address
    input  wire logic                      reg_work_i,     // working mode
    input  wire logic                      reg_rd_i,       // read strobe
    input  wire logic                      reg_wr_i,       // write strobe
    input  wire logic [`RF_DATA_W-1:0]     reg_wdata_i,    // write data
    output logic      [`RF_DATA_W-1:0]     reg_rdata_o,    // read answer
    output logic                           reg_rvalid_o,   // answer strobe
    output logic      [`RF_PAGE_W-1:0]     page_sel_o,     // page pointer
    // paged peripheral window
    output logic                           per_rd_o,       // read strobe
    output logic                           per_wr_o,       // write strobe
    output logic      [`RF_PAGE_W-1:0]     per_page_o,     // page number
    output logic      [`RF_IDX_W-1:0]      per_idx_o,      // reg in page
    output logic      [`RF_DATA_W-1:0]     per_wdata_o,    // write data
    input  wire logic [`RF_DATA_W-1:0]     per_rdata_i,    // read data
    // memory bus from the core
    input  wire logic                      mem_req_i,      // request
    input  wire logic                      mem_data_i,     // 1 data, 0 prog
    input  wire logic                      mem_we_i,       // write
    input  wire logic [`RF_MEM_ADDR_W-1:0] mem_addr_i,     // address
    output logic                           prog_req_o,     // program req
    output logic                           data_req_o,     // data req
    output logic                           mem_we_o,       // data write
    output logic      [`RF_MEM_ADDR_W-1:0] mem_addr_o,     // address
    // interrupt/dma bus
    input  wire logic [`RF_INT_W-1:0]      int_core_i,     // from core
    output logic      [`RF_INT_W-1:0]      int_per_o,      // to peripherals
    input  wire logic [`RF_INT_W-1:0]      int_per_i,      // from periphs
    output logic      [`RF_INT_W-1:0]      int_core_o      // to core
);

    // refuse a general-purpose size that overlaps the system group
    // a smaller store leaves its upper addresses reading zero
    if (GP_COUNT < 1 || GP_COUNT > `RF_GP_COUNT) begin : g_bad_gp
        $error("general-purpose count out of range");
    end

    // the whole decoder state lives in one packed struct: q is the
    // registered copy, d the value it takes at the next edge
    regfile_pkg::dec_state_t q;  // current state
    regfile_pkg::dec_state_t d;  // next state

    // decode results, combinational except the storage read data
    logic [`RF_ADDR_W-1:0]  eff_addr;   // address after working mode
    regfile_pkg::region_t   region;     // region of this access
    logic [`RF_PAGE_W-1:0]  cur_page;   // page pointer value
    logic                   page_ok;    // selected page exists
    logic                   gp_we;      // write into storage
    logic [`RF_DATA_W-1:0]  gp_rdata;   // storage read data
    logic [`RF_SYS_COUNT-1:0] sys_we;   // write strobe per system reg

    // address forming and region decode
    always_comb begin
        // both pointers are read from the registered copy, so a pointer
        // write is seen by the access in the following cycle, never by
        // the access that carries the write itself
        // working mode takes the high nibble from the pointer
        if (reg_work_i) begin
            eff_addr = {q.sys[`RF_RP_IDX][7:4], reg_addr_i[3:0]};
        end else begin
            eff_addr = reg_addr_i;  // direct 8-bit address
        end
        // page pointer selects one of 64 pages
        cur_page = q.sys[`RF_PP_IDX][`RF_PAGE_W-1:0];
        page_ok  = PAGE_PRESENT[cur_page];
        // three regions of the 8-bit space
        if (eff_addr <= `RF_GP_LAST) begin
            region = regfile_pkg::REG_GP;
        end else if (eff_addr <= `RF_SYS_LAST) begin
            region = regfile_pkg::REG_SYS;
        end else if (page_ok) begin
            region = regfile_pkg::REG_PAGE;
        end else begin
            region = regfile_pkg::REG_ABSENT;
        end
        // storage is written only for addresses of its own region
        gp_we = reg_wr_i && (region == regfile_pkg::REG_GP);
    end

    // one write strobe per system register, decoded per entry
    for (genvar gi = 0; gi < `RF_SYS_COUNT; gi++) begin : g_sys_we
        // this entry is written when the low nibble names it
        assign sys_we[gi] = reg_wr_i
            && (region == regfile_pkg::REG_SYS)
            && (eff_addr[3:0] == 4'(gi));
    end

    // storage answers one edge after the address; the read pipeline
    // below waits one edge more, so that every region answers alike
    // general-purpose storage, read data registered inside
    gp_ram #(
        .DEPTH  (GP_COUNT),
        .WIDTH  (`RF_DATA_W),
        .ADDR_W (`RF_ADDR_W)
    ) u_gp_ram (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .we_i      (gp_we),
        .addr_i    (eff_addr),
        .wdata_i   (reg_wdata_i),
        .rdata_o   (gp_rdata)
    );

    // next-state logic for registers, window and side buses
    always_comb begin
        d = q;
        // system group writes, value kept until rewritten
        for (int i = 0; i < `RF_SYS_COUNT; i++) begin
            if (sys_we[i]) begin
                d.sys[i] = reg_wdata_i;
            end
        end
        // a read is taken in two stages so that storage, system group
        // and peripheral window all answer exactly two edges later
        // first read stage: remember region and system value
        d.rd_pend   = reg_rd_i;
        d.rd_region = region;
        d.sys_val   = q.sys[eff_addr[3:0]];
        // page number, index and data hold between window accesses so
        // that a peripheral may look at them late without harm
        // window strobes only reach a present page
        d.periph_rd = reg_rd_i && (region == regfile_pkg::REG_PAGE);
        d.periph_wr = reg_wr_i && (region == regfile_pkg::REG_PAGE);
        if (region == regfile_pkg::REG_PAGE) begin
            d.periph_page  = cur_page;
            d.periph_idx   = eff_addr[3:0];
            d.periph_wdata = reg_wdata_i;
        end
        // the peripheral drives its read data while the strobe stands,
        // so its answer is sampled at the end of that cycle
        // second read stage: pick the answer
        d.rd_valid = q.rd_pend;
        case (q.rd_region)
            regfile_pkg::REG_GP:     d.rd_data = gp_rdata;
            regfile_pkg::REG_SYS:    d.rd_data = q.sys_val;
            regfile_pkg::REG_PAGE:   d.rd_data = per_rdata_i;
            regfile_pkg::REG_ABSENT: d.rd_data = `RF_ABSENT_VAL;
            default:                 d.rd_data = `RF_ABSENT_VAL;
        endcase
        if (!q.rd_pend) begin
            d.rd_data = q.rd_data;  // hold last answer
        end
        // a program-space request never carries a write: program space
        // is read-only from this side of the block
        // memory bus steered to distinct spaces
        d.prog_req = mem_req_i && !mem_data_i;
        d.data_req = mem_req_i && mem_data_i;
        d.mem_we   = mem_req_i && mem_data_i && mem_we_i;
        if (mem_req_i) begin
            d.mem_addr = mem_addr_i;
        end
        // the interrupt/dma lines are registered in each direction with
        // one cycle of delay, their meaning is not decoded here
        // interrupt/dma bus passed both ways
        d.int_to_per  = int_core_i;
        d.int_to_core = int_per_i;
    end

    // state register, synchronous reset
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            q <= '0;
            // the system group restarts too, so page pointer and
            // register pointer both begin at zero
            for (int i = 0; i < `RF_SYS_COUNT; i++) begin
                q.sys[i] <= `RF_SYS_RST;
            end
        end else begin
            q <= d;
        end
    end

    // every output is a bit of the state register, with no logic
    // between the flip-flops and the pins
    // outputs straight from the state register
    assign reg_rdata_o  = q.rd_data;
    assign reg_rvalid_o = q.rd_valid;
    assign page_sel_o   = q.sys[`RF_PP_IDX][`RF_PAGE_W-1:0];
    assign per_rd_o     = q.periph_rd;
    assign per_wr_o     = q.periph_wr;
    assign per_page_o   = q.periph_page;
    assign per_idx_o    = q.periph_idx;
    assign per_wdata_o  = q.periph_wdata;
    assign prog_req_o   = q.prog_req;
    assign data_req_o   = q.data_req;
    assign mem_we_o     = q.mem_we;
    assign mem_addr_o   = q.mem_addr;
    assign int_per_o    = q.int_to_per;
    assign int_core_o   = q.int_to_core;

endmodule : paged_register_file_decoder

`default_nettype wire

// *** core/regfile_consts.svh ***
// Purpose: constants of the paged register file decoder
// Assumes: included by bare name from package and modules
// Notes:   offsets are register-file addresses, counts are decimal
`ifndef REGFILE_CONSTS_SVH
`define REGFILE_CONSTS_SVH

`define RF_ADDR_W      8           // register addressing bus width
`define RF_DATA_W      8           // byte-wide registers
`define RF_GP_COUNT    224         // general-purpose locations
`define RF_GP_LAST     8'hdf       // last general-purpose address
`define RF_SYS_BASE    8'he0       // first system register
`define RF_SYS_LAST    8'hef       // last system register
`define RF_SYS_COUNT   16          // registers in the system group
`define RF_PAGE_BASE   8'hf0       // first paged window address
`define RF_PAGE_REGS   16          // registers per peripheral page
`define RF_PAGE_COUNT  64          // most pages that can exist
`define RF_PAGE_W      6           // page number width
`define RF_IDX_W       4           // register index within a group
`define RF_RP_IDX      4'h9        // register pointer, index in group e
`define RF_PP_IDX      4'ha        // page pointer, index in group e
`define RF_SYS_RST     8'h00       // system register reset value
`define RF_ABSENT_VAL  8'hff       // read value of an absent page
`define RF_MEM_ADDR_W  16          // memory bus width
`define RF_INT_W       6           // interrupt/dma bus width

`endif

// *** core/regfile_pkg.sv ***
// Purpose: types shared by the register file decoder
// Assumes: constants come from regfile_consts.svh
// Notes:   whole decoder state is one packed struct
`include "regfile_consts.svh"

package regfile_pkg;

    // region hit by a register access
    typedef enum logic [1:0] {
        REG_GP,
        REG_SYS,
        REG_PAGE,
        REG_ABSENT
    } region_t;

    typedef logic [`RF_DATA_W-1:0] byte_t;  // one register

    // complete state of the decoder
    typedef struct packed {
        byte_t [`RF_SYS_COUNT-1:0]  sys;          // system group
        logic                       rd_pend;      // read taken last cycle
        region_t                    rd_region;    // region of that read
        byte_t                      sys_val;      // captured system value
        logic                       rd_valid;     // read answer strobe
        byte_t                      rd_data;      // read answer
        logic                       periph_rd;    // peripheral read strobe
        logic                       periph_wr;    // peripheral write strobe
        logic [`RF_PAGE_W-1:0]      periph_page;  // page being accessed
        logic [`RF_IDX_W-1:0]       periph_idx;   // register in page
        byte_t                      periph_wdata; // peripheral write data
        logic                       prog_req;     // program memory request
        logic                       data_req;     // data memory request
        logic                       mem_we;       // data memory write
        logic [`RF_MEM_ADDR_W-1:0]  mem_addr;     // memory address
        logic [`RF_INT_W-1:0]       int_to_per;   // core to peripherals
        logic [`RF_INT_W-1:0]       int_to_core;  // peripherals to core
    } dec_state_t;

endpackage : regfile_pkg

// *** sim/paged_register_file_decoder_test.sv ***
// Purpose: scenario bench for the paged register file decoder
// Assumes: default parameters, pages 0 to 3 present
// Notes:   inputs change on the falling edge
`include "regfile_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module paged_register_file_decoder_test;
    logic ref_clk_i = 1'h0, reset_i = 1'h1, reg_work_i = 1'h0;
    logic reg_rd_i = 1'h0, reg_wr_i = 1'h0, mem_req_i = 1'h0;
    logic mem_data_i = 1'h0, mem_we_i = 1'h0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, got;
    logic [15:0] mem_addr_i = 16'h0000, mem_addr_o;
    logic [5:0] int_core_i = 6'h00, int_per_i = 6'h00, int_per_o;
    logic [5:0] int_core_o, page_sel_o, per_page_o;
    logic [7:0] reg_rdata_o, per_rdata_i, per_wdata_o;
    logic [3:0] per_idx_o;
    logic reg_rvalid_o, per_rd_o, per_wr_o, prog_req_o, data_req_o, mem_we_o;
    wire logic [18:0] mem_out =  // memory bus outputs, data side first
        {data_req_o, prog_req_o, mem_we_o, mem_addr_o};
    int fail_count = 0, cmp_count = 0, cycles = 0;

    paged_register_file_decoder paged_register_file_decoder_i (.ref_clk_i,
        .reset_i, .reg_addr_i, .reg_work_i, .reg_rd_i, .reg_wr_i, .reg_wdata_i,
        .reg_rdata_o, .reg_rvalid_o, .page_sel_o, .per_rd_o, .per_wr_o,
        .per_page_o, .per_idx_o, .per_wdata_o, .per_rdata_i, .mem_req_i,
        .mem_data_i, .mem_we_i, .mem_addr_i, .prog_req_o, .data_req_o,
        .mem_we_o, .mem_addr_o, .int_core_i, .int_per_o, .int_per_i,
        .int_core_o);
    periph_model periph_model_i (.ref_clk_i, .per_rd_o, .per_wr_o,
        .per_page_o, .per_idx_o, .per_wdata_o, .per_rdata_i);

    always #10 ref_clk_i = ~ref_clk_i;
    // hang guard
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk

    // one register access; a read waits for its answer
    task automatic acc(input logic r, wk, input logic [7:0] a, d);
        int n;
        @(negedge ref_clk_i);
        {reg_rd_i, reg_wr_i, reg_work_i} = {r, ~r, wk};
        {reg_addr_i, reg_wdata_i} = {a, d};
        @(negedge ref_clk_i);
        {reg_rd_i, reg_wr_i} = 2'h0;
        n = 0;
        while (r && reg_rvalid_o !== 1'h1 && n < 4) begin
            @(negedge ref_clk_i);
            n++;
        end
        got = reg_rdata_o;
        if (r) chk(24'(n), 24'h000001);
    endtask : acc

    task automatic t_gp();
        acc(1'h0, 1'h0, 8'h00, 8'h5a);
        acc(1'h0, 1'h0, 8'hdf, 8'ha5);
        acc(1'h1, 1'h0, 8'h00, 8'h00);
        chk(got, 8'h5a);
        acc(1'h1, 1'h0, 8'hdf, 8'h00);
        chk(got, 8'ha5);
        acc(1'h0, 1'h0, 8'he9, 8'h50);
        acc(1'h0, 1'h1, 8'h03, 8'h77);
        acc(1'h1, 1'h0, 8'h53, 8'h00);
        chk(got, 8'h77);
    endtask : t_gp

    task automatic t_sys();
        acc(1'h1, 1'h0, 8'he5, 8'h00);
        chk(got, 8'h00);
        acc(1'h0, 1'h0, 8'he0, 8'h3c);
        acc(1'h0, 1'h0, 8'hef, 8'hc3);
        acc(1'h1, 1'h0, 8'he0, 8'h00);
        chk(got, 8'h3c);
        acc(1'h1, 1'h0, 8'hef, 8'h00);
        chk(got, 8'hc3);
        acc(1'h1, 1'h0, 8'h00, 8'h00);
        chk(got, 8'h5a);
    endtask : t_sys

    task automatic t_page();
        acc(1'h0, 1'h0, 8'hea, 8'h02);
        chk(page_sel_o, 6'h02);
        acc(1'h0, 1'h0, 8'hf5, 8'h9e);
        acc(1'h0, 1'h0, 8'hea, 8'h03);
        acc(1'h0, 1'h0, 8'hf5, 8'h44);
        acc(1'h0, 1'h0, 8'hea, 8'h3f);
        acc(1'h0, 1'h0, 8'hf5, 8'h11);
        acc(1'h1, 1'h0, 8'hf5, 8'h00);
        chk(got, `RF_ABSENT_VAL);
        acc(1'h0, 1'h0, 8'hea, 8'h02);
        acc(1'h1, 1'h0, 8'hf5, 8'h00);
        chk(got, 8'h9e);
        acc(1'h0, 1'h0, 8'he9, 8'hf0);
        acc(1'h1, 1'h1, 8'h05, 8'h00);
        chk(got, 8'h9e);
        acc(1'h0, 1'h0, 8'hea, 8'h03);
        acc(1'h1, 1'h0, 8'hf5, 8'h00);
        chk(got, 8'h44);
    endtask : t_page

    // memory traffic alongside a register read
    task automatic t_mem();
        @(negedge ref_clk_i);
        {mem_req_i, mem_data_i, mem_we_i, mem_addr_i} = {3'h7, 16'hbeef};
        acc(1'h1, 1'h0, 8'hdf, 8'h00);
        chk(got, 8'ha5);
        chk(mem_out, 24'h05beef);
        {mem_data_i, mem_addr_i} = {1'h0, 16'h1234};
        @(negedge ref_clk_i);
        chk(mem_out, 24'h021234);
        mem_req_i = 1'h0;
        @(negedge ref_clk_i);
        chk(mem_out, 24'h001234);
    endtask : t_mem

    task automatic t_int();
        for (int i = 0; i < 6; i++) begin
            {int_core_i, int_per_i} = {6'h01 << i, ~(6'h01 << i)};
            @(negedge ref_clk_i);
            chk({int_per_o, int_core_o}, {int_core_i, int_per_i});
        end
    endtask : t_int

    // reset in mid-run clears storage and page pointer
    task automatic t_reset();
        reset_i = 1'h1;
        repeat (2) @(negedge ref_clk_i);
        reset_i = 1'h0;
        chk(page_sel_o, 6'h00);
        acc(1'h1, 1'h0, 8'h00, 8'h00);
        chk(got, 8'h00);
    endtask : t_reset

    initial begin
        repeat (4) @(negedge ref_clk_i);
        reset_i = 1'h0;
        t_gp();
        t_sys();
        t_page();
        t_mem();
        t_int();
        t_reset();
        give_verdict();
    end
endmodule : paged_register_file_decoder_test

bind paged_register_file_decoder regfile_dec_sva #(
    .PAGE_PRESENT(PAGE_PRESENT)) regfile_dec_sva_i (.ref_clk_i, .reset_i,
    .reg_addr_i, .reg_work_i, .reg_rd_i, .reg_wr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .page_sel_o, .per_rd_o, .per_wr_o,
    .per_page_o, .per_idx_o, .per_wdata_o, .mem_req_i, .mem_data_i,
    .mem_we_i, .mem_addr_i, .prog_req_o, .data_req_o, .mem_we_o,
    .mem_addr_o, .int_core_i, .int_per_o, .int_per_i, .int_core_o);
`default_nettype wire

// *** sim/periph_model.sv ***
// Purpose: peripheral page registers behind the decoder window
// Assumes: strobes are one-cycle pulses
// Notes:   idle read data is the inverse of the last answer
`timescale 1ns/1ps
`default_nettype none
module periph_model (
    input  wire logic       ref_clk_i,   // core clock
    input  wire logic       per_rd_o,    // read strobe
    input  wire logic       per_wr_o,    // write strobe
    input  wire logic [5:0] per_page_o,  // page number
    input  wire logic [3:0] per_idx_o,   // register in page
    input  wire logic [7:0] per_wdata_o, // write data
    output logic      [7:0] per_rdata_i  // read data
);
    logic [7:0] store [1024];  // 64 pages of 16 bytes
    logic [7:0] last = 8'h00;  // last answer given
    initial foreach (store[k]) store[k] = 8'h00;
    // writes land in the addressed page register
    always @(posedge ref_clk_i) begin
        if (per_wr_o) begin
            store[{per_page_o, per_idx_o}] <= per_wdata_o;
        end
        if (per_rd_o) begin
            last <= per_rdata_i;  // remember the answer
        end
    end
    // answer in the strobe cycle, a changed value otherwise
    assign per_rdata_i = per_rd_o ? store[{per_page_o, per_idx_o}]
                                  : ~last;
endmodule : periph_model
`default_nettype wire

// *** sim/regfile_dec_sva.sv ***
// Purpose: port assertions for the paged register file decoder
// Assumes: one clock, synchronous reset high
// Notes:   bound from the testbench top file
`include "regfile_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module regfile_dec_sva #(
    parameter logic [63:0] PAGE_PRESENT = 64'h0000_0000_0000_000f
) (
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_work_i,
    input wire logic        reg_rd_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic [5:0]  page_sel_o,
    input wire logic        per_rd_o,
    input wire logic        per_wr_o,
    input wire logic [5:0]  per_page_o,
    input wire logic [3:0]  per_idx_o,
    input wire logic [7:0]  per_wdata_o,
    input wire logic        mem_req_i,
    input wire logic        mem_data_i,
    input wire logic        mem_we_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic        prog_req_o,
    input wire logic        data_req_o,
    input wire logic        mem_we_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic [5:0]  int_core_i,
    input wire logic [5:0]  int_per_o,
    input wire logic [5:0]  int_per_i,
    input wire logic [5:0]  int_core_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // direct access to the top group, and whether its page exists
    wire logic hit = (reg_addr_i[7:4] == 4'hf) && !reg_work_i;
    wire logic present = PAGE_PRESENT[page_sel_o];

    a_read_answer: assert property (reg_rd_i |-> ##2 reg_rvalid_o)
        else $error("read not answered two edges later");
    a_no_answer: assert property (
        !reg_rd_i |-> ##2 !reg_rvalid_o)
        else $error("answer strobe without a read");
    a_page_read: assert property (
        reg_rd_i && hit && present |=> per_rd_o
        && per_idx_o == $past(reg_addr_i[3:0])
        && per_page_o == $past(page_sel_o))
        else $error("page read strobe wrong");
    a_absent_read: assert property (
        reg_rd_i && hit && !present |=> !per_rd_o
        ##1 reg_rdata_o == `RF_ABSENT_VAL)
        else $error("absent read wrong");
    a_page_write: assert property (
        reg_wr_i && hit && present |=> per_wr_o
        && per_wdata_o == $past(reg_wdata_i))
        else $error("page write wrong");
    a_absent_write: assert property (
        reg_wr_i && hit && !present |=> !per_wr_o)
        else $error("absent page write reached peripheral");
    a_ptr_load: assert property (
        reg_wr_i && hit == 1'h0 && !reg_work_i && reg_addr_i == 8'hea
        |=> page_sel_o == $past(reg_wdata_i[5:0]))
        else $error("page pointer not loaded");
    a_ptr_holds: assert property (
        !reg_wr_i |=> $stable(page_sel_o))
        else $error("page pointer changed without write");
    a_data_mem: assert property (
        mem_req_i && mem_data_i |=> data_req_o
        && !prog_req_o && mem_we_o == $past(mem_we_i)
        && mem_addr_o == $past(mem_addr_i))
        else $error("data request wrong");
    a_prog_mem: assert property (
        mem_req_i && !mem_data_i |=> prog_req_o
        && !data_req_o && !mem_we_o)
        else $error("program request wrong");
    a_int_copy: assert property (
        1'h1 |=> int_per_o == $past(int_core_i)
        && int_core_o == $past(int_per_i))
        else $error("interrupt bus copy wrong");

    c_page_read: cover property (reg_rd_i && hit && present);
    c_absent_read: cover property (reg_rd_i && hit && !present);
    c_data_write: cover property (mem_req_i && mem_data_i && mem_we_i);
endmodule : regfile_dec_sva
`default_nettype wire
